// file: test/ard_front_end_model.sv
// Reference pair and detector comparators of the analog front end.
`timescale 1ns/1ps
module ard_front_end_model (
  // Pair voltage in millivolts.
  input logic [11:0] refMv,
  // Detector levels.
  output logic belowLow,
  output logic aboveHigh
);
  // Between the thresholds both levels stay low.
  assign belowLow = refMv < 12'h12C;
  assign aboveHigh = refMv > 12'h258;
endmodule // ard_front_end_model

// file: test/ard_reference_control_monitor.sv
// Port checker for the reference-detect control block.
`timescale 1ns/1ps
module ard_reference_control_monitor #(
  parameter CHAN_WIDTH = 4
) (
  // Clock and reset.
  input logic clk_sys,
  input logic reset_n,
  // Register bus.
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  // Front end.
  input logic conversionDone,
  input logic calibrationDone,
  input logic [CHAN_WIDTH-1:0] activeChannel,
  input logic offsetCalRunning,
  input logic fullScaleCalRunning,
  input logic clockOutPin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire wGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  AST_BVALID_LATENCY: assert property (wGo |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  AST_SLVERR: assert property (wGo && s_axi_awaddr > 8'h1C |=> ##1 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_RVALID_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_CHANNEL_SYNC: assert property (!$stable(activeChannel) |-> $past(conversionDone))
    else $error("channel switched mid conversion");
  AST_CAL_EXCLUSIVE: assert property (!(offsetCalRunning && fullScaleCalRunning))
    else $error("two calibrations at once");
  AST_CAL_END: assert property (calibrationDone && offsetCalRunning |=> !offsetCalRunning)
    else $error("calibration did not end");
  AST_OSC_HIGH: assert property ($rose(clockOutPin) |=> clockOutPin [*8])
    else $error("oscillator half period short");
  cover property (calibrationDone && offsetCalRunning);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (!$stable(activeChannel));
endmodule // ard_reference_control_monitor

bind ard_reference_control ard_reference_control_monitor #(.CHAN_WIDTH(CHAN_WIDTH)) i_ard_reference_control_monitor (
  .clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .conversionDone, .calibrationDone, .activeChannel, .offsetCalRunning, .fullScaleCalRunning, .clockOutPin
);

// file: test/ard_reference_control_tb_top.sv
// Self-checking bench for the reference-detect control block.
`timescale 1ns/1ps
`include "ard_defines.vh"
module ard_reference_control_tb_top;
  typedef struct {logic [31:0] cfg; logic [2:0] g; logic oe;} ard_row_t;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic conversionDone = 1'h0, calibrationDone = 1'h0, extClockIn = 1'h0;
  logic [23:0] conversionResult = 24'h0;
  logic [11:0] mvA = 12'h384, mvB = 12'h384;
  logic firstRefBelowLow, firstRefAboveHigh, secondRefBelowLow, secondRefAboveHigh;
  logic secondRefPinsAsReference, bufferEnable, clockOutPinEnable_n, irq;
  logic [2:0] gainSelect;
  logic [3:0] activeChannel;
  logic conversionRestart, offsetCalRunning, fullScaleCalRunning, masterClock, clockOutPin;
  logic [23:0] calibrationValueOut;
  int errors = 0;
  int nChecks = 0;
  ard_row_t rows [6] = '{'{32'h0000_0000, `ARD_GAIN_1, 1'h1}, '{32'h0000_001C, `ARD_GAIN_8, 1'h1},
    '{32'h0000_0022, `ARD_GAIN_16, 1'h1}, '{32'h0000_002E, `ARD_GAIN_32, 1'h1},
    '{32'h0000_00B0, `ARD_GAIN_64, 1'h0}, '{32'h0000_00F8, `ARD_GAIN_128, 1'h1}};
  ard_reference_control i_ard_reference_control (
    .clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .firstRefBelowLow, .firstRefAboveHigh,
    .secondRefBelowLow, .secondRefAboveHigh, .conversionDone, .conversionResult, .calibrationDone, .extClockIn,
    .secondRefPinsAsReference, .gainSelect, .bufferEnable, .activeChannel, .conversionRestart,
    .offsetCalRunning, .fullScaleCalRunning, .calibrationValueOut, .masterClock, .clockOutPin,
    .clockOutPinEnable_n, .irq
  );
  ard_front_end_model i_ard_front_end_model (.refMv(mvA), .belowLow(firstRefBelowLow), .aboveHigh(firstRefAboveHigh));
  ard_front_end_model i_ard_front_end_model_b (.refMv(mvB), .belowLow(secondRefBelowLow), .aboveHigh(secondRefAboveHigh));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) extClockIn <= ~extClockIn;
  task automatic wrap_up;
    if (errors == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Values are sampled at the falling edge, so they hold at the next rising edge.
  task automatic xfer(bit w, logic [7:0] a, logic [31:0] d);
    int k;
    logic aw, wd, ar, v, hs;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys);
      aw = s_axi_awvalid && s_axi_awready;
      wd = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      v = w ? s_axi_bvalid : s_axi_rvalid;
      hs = v && (w ? s_axi_bready : s_axi_rready);
      resp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 1'h0;
      if (wd) s_axi_wvalid <= 1'h0;
      if (ar) s_axi_arvalid <= 1'h0;
      if (hs) break;
    end
    if (k == 50) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  task automatic pulse(bit cal, logic [23:0] v);
    conversionResult <= v;
    conversionDone <= !cal;
    calibrationDone <= cal;
    @(posedge clk_sys);
    conversionDone <= 1'h0;
    calibrationDone <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic look(string n, logic [31:0] e, logic [31:0] g);
    chk(n, e, g);
    @(posedge clk_sys);
  endtask
  // Counts level changes of the oscillator pin or the master clock over 100 cycles.
  task automatic toggles(string n, bit m, int e);
    int c;
    logic p;
    c = 0;
    @(negedge clk_sys);
    p = m ? masterClock : clockOutPin;
    repeat (100) begin
      @(negedge clk_sys);
      if ((m ? masterClock : clockOutPin) !== p) c++;
      p = m ? masterClock : clockOutPin;
    end
    chk(n, e, c);
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(negedge clk_sys);
    chk("irq", 32'h0, irq);
    look("clkOe", 32'h1, clockOutPinEnable_n);
    rdc("config", `ARD_OFF_CONFIG, 32'hFFFF_FFFF, `ARD_CFG_RESET);
    rdc("offset", `ARD_OFF_OFFSET_COEF, 32'hFFFF_FFFF, 32'h0080_0000);
    rdc("fullscale", `ARD_OFF_FULLSCALE_COEF, 32'hFFFF_FFFF, 32'h0050_0000);
    foreach (rows[i]) begin
      wr(`ARD_OFF_CONFIG, rows[i].cfg);
      @(negedge clk_sys);
      chk("gain", rows[i].g, gainSelect);
      chk("buffer", rows[i].cfg[2], bufferEnable);
      chk("refChoice", rows[i].cfg[1], secondRefPinsAsReference);
      look("clkOe", rows[i].oe, clockOutPinEnable_n);
      rdc("config", `ARD_OFF_CONFIG, 32'h0000_00FF, rows[i].cfg);
    end
    toggles("extClock", 1'h1, 100);
    wr(`ARD_OFF_CONFIG, 32'h1);
    mvA <= 12'h064;
    repeat (6) @(posedge clk_sys);
    rdc("missing_reference_flag", `ARD_OFF_STATUS, 32'h1, 32'h1);
    pulse(1'h0, 24'h12_3456);
    rdc("result", `ARD_OFF_RESULT, 32'h00FF_FFFF, 32'h00FF_FFFF);
    rdc("missing_reference_flag", `ARD_OFF_STATUS, 32'h1, 32'h1);
    mvA <= 12'h1C2;
    repeat (6) @(posedge clk_sys);
    rdc("hold", `ARD_OFF_STATUS, 32'h1, 32'h1);
    mvA <= 12'h384;
    repeat (6) @(posedge clk_sys);
    rdc("valid", `ARD_OFF_STATUS, 32'h1, 32'h0);
    pulse(1'h0, 24'h12_3456);
    rdc("result", `ARD_OFF_RESULT, 32'h00FF_FFFF, 32'h0012_3456);
    wr(`ARD_OFF_IRQ_MASK, 32'h1);
    @(negedge clk_sys);
    look("irqUp", 32'h1, irq);
    wr(`ARD_OFF_STATUS, 32'h1);
    @(negedge clk_sys);
    look("irqClear", 32'h0, irq);
    wr(`ARD_OFF_CONFIG, 32'h0);
    toggles("oscPin", 1'h0, 100 / `ARD_INT_OSC_DIV);
    toggles("oscMaster", 1'h1, 100 / `ARD_INT_OSC_DIV);
    mvA <= 12'h064;
    repeat (6) @(posedge clk_sys);
    rdc("detectOff", `ARD_OFF_STATUS, 32'h1, 32'h0);
    wr(`ARD_OFF_CONFIG, 32'h3);
    repeat (6) @(posedge clk_sys);
    rdc("pairB", `ARD_OFF_STATUS, 32'h1, 32'h0);
    mvB <= 12'h064;
    repeat (6) @(posedge clk_sys);
    rdc("pairB", `ARD_OFF_STATUS, 32'h1, 32'h1);
    @(negedge clk_sys);
    look("irqB", 32'h1, irq);
    wr(`ARD_OFF_IRQ_MASK, 32'h0);
    @(negedge clk_sys);
    look("irqMasked", 32'h0, irq);
    wr(`ARD_OFF_CAL_CTRL, 32'h1);
    @(negedge clk_sys);
    chk("offRun", 32'h1, offsetCalRunning);
    look("calValue", 32'h0080_0000, calibrationValueOut);
    pulse(1'h1, 24'h11_1111);
    rdc("offKeep", `ARD_OFF_OFFSET_COEF, 32'h00FF_FFFF, 32'h0080_0000);
    rdc("calErr", `ARD_OFF_STATUS, 32'h2, 32'h2);
    mvB <= 12'h384;
    repeat (6) @(posedge clk_sys);
    wr(`ARD_OFF_STATUS, 32'hF);
    wr(`ARD_OFF_CAL_CTRL, 32'h2);
    @(negedge clk_sys);
    chk("fsRun", 32'h1, fullScaleCalRunning);
    look("calValueFs", 32'h0050_0000, calibrationValueOut);
    pulse(1'h1, 24'h22_2222);
    rdc("fsNew", `ARD_OFF_FULLSCALE_COEF, 32'h00FF_FFFF, 32'h0022_2222);
    rdc("calErr", `ARD_OFF_STATUS, 32'h2, 32'h0);
    wr(`ARD_OFF_CHANNEL, 32'h5);
    @(negedge clk_sys);
    look("chanWait", 32'h0, activeChannel);
    conversionDone <= 1'h1;
    @(posedge clk_sys);
    conversionDone <= 1'h0;
    @(negedge clk_sys);
    chk("restart", 32'h1, conversionRestart);
    look("chanNew", 32'h5, activeChannel);
    wr(8'h20, 32'h1);
    chk("bresp", 32'h2, resp);
    rdc("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0);
    chk("rresp", 32'h2, resp);
    // A reset in mid-run must bring the channel and the full-scale coefficient back.
    reset_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(negedge clk_sys);
    look("chanReset", 32'h0, activeChannel);
    rdc("fsReset", `ARD_OFF_FULLSCALE_COEF, 32'hFFFF_FFFF, 32'h0050_0000);
    wrap_up();
  end
endmodule // ard_reference_control_tb_top

// file: verilog/ard_defines.vh
// Register offsets, field positions, reset values and timing counts of the reference-detect control block.
`ifndef ARD_DEFINES_VH
`define ARD_DEFINES_VH
`define ARD_OFF_CONFIG 8'h00
`define ARD_OFF_STATUS 8'h04
`define ARD_OFF_IRQ_MASK 8'h08
`define ARD_OFF_CAL_CTRL 8'h0C
`define ARD_OFF_OFFSET_COEF 8'h10
`define ARD_OFF_FULLSCALE_COEF 8'h14
`define ARD_OFF_RESULT 8'h18
`define ARD_OFF_CHANNEL 8'h1C
`define ARD_CFG_REF_DETECT_ENABLE 0
`define ARD_CFG_REFERENCE_CHOICE 1
`define ARD_CFG_BUFFER_ENABLE 2
`define ARD_CFG_GAIN_LSB 3
`define ARD_CFG_GAIN_MSB 5
`define ARD_CFG_EXT_CLOCK 6
`define ARD_CFG_CLOCK_OUT_ENABLE 7
`define ARD_CFG_RESET 32'h0000_0000
`define ARD_ST_MISSING_REF 0
`define ARD_ST_ERROR 1
`define ARD_ST_RESULT_READY 2
`define ARD_ST_CAL_DONE 3
`define ARD_CAL_START_OFFSET 0
`define ARD_CAL_START_FULLSCALE 1
`define ARD_OFFSET_COEF_RESET 24'h80_0000
`define ARD_FULLSCALE_COEF_RESET 24'h50_0000
`define ARD_GAIN_1 3'h0
`define ARD_GAIN_8 3'h3
`define ARD_GAIN_16 3'h4
`define ARD_GAIN_32 3'h5
`define ARD_GAIN_64 3'h6
`define ARD_GAIN_128 3'h7
`define ARD_INT_OSC_KHZ 4920
`define ARD_SYS_CLK_KHZ 100000
`define ARD_INT_OSC_DIV (`ARD_SYS_CLK_KHZ / (2 * `ARD_INT_OSC_KHZ))
`endif

// file: verilog/ard_reference_control.v
// Reference-detect, calibration guard and input configuration control for a sigma-delta front end.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ard_defines.vh"

// Function
// RL1 - Reference detection runs only while the detect-enable configuration bit is one.
// RL2 - Reference below the low threshold sets the missing-reference flag.
// RL3 - Reference above the high threshold clears the missing-reference flag.
// RL4 - Between thresholds the flag value is undefined; the bench expects the flag to hold its value there.
// RL5 - While the flag is active, each conversion result becomes all ones.
// RL6 - Flag active during calibration blocks the coefficient update and sets error.
// RL7 - Host checks flag only on all-ones results, error after each calibration.
// RL8 - Reference-choice bit selects pair; one turns dual pins into reference inputs.
// RL9 - Three-bit gain field selects gain 1, 8, 16, 32, 64 or 128.
// RL10 - Buffer bit one routes through the buffer, zero bypasses it.
// RL11 - Channel changes take effect only at conversion boundaries.
// RL12 - Master clock is internal oscillator or external clock; internal may drive a pin.
// RL13 - Flag holds between thresholds and comparators pass a synchroniser first.
module ard_reference_control #(
  parameter RESULT_WIDTH = 24,
  parameter CHAN_WIDTH = 4
) (
  // Clock and reset.
  input wire clk_sys,
  input wire reset_n,
  // AXI4-Lite write address and data.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read.
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Reference comparators of the first and second pair (asynchronous).
  input wire firstRefBelowLow,
  input wire firstRefAboveHigh,
  input wire secondRefBelowLow,
  input wire secondRefAboveHigh,
  // Modulator side: conversion and calibration events.
  input wire conversionDone,
  input wire [RESULT_WIDTH-1:0] conversionResult,
  input wire calibrationDone,
  // Clock source: external master clock sampled as a level.
  input wire extClockIn,
  // Analog front-end controls.
  output reg secondRefPinsAsReference,
  output reg [2:0] gainSelect,
  output reg bufferEnable,
  output reg [CHAN_WIDTH-1:0] activeChannel,
  output reg conversionRestart,
  output reg offsetCalRunning,
  output reg fullScaleCalRunning,
  output reg [RESULT_WIDTH-1:0] calibrationValueOut,
  // Clocking outputs.
  output reg masterClock,
  output reg clockOutPin,
  output reg clockOutPinEnable_n,
  // Interrupt.
  output reg irq
);

  localparam [1:0] CAL_IDLE = 2'h0;
  localparam [1:0] CAL_OFFSET = 2'h1;
  localparam [1:0] CAL_FULLSCALE = 2'h2;
  // The divider count is cut to the counter width on purpose.
  localparam integer OSC_DIV_FULL = `ARD_INT_OSC_DIV;
  localparam [15:0] OSC_DIV = OSC_DIV_FULL[15:0];

  reg [31:0] config_r;
  reg [3:0] status_r;
  reg [3:0] irqMask_r;
  reg [23:0] offsetCoef_r;
  reg [23:0] fullScaleCoef_r;
  reg [RESULT_WIDTH-1:0] result_r;
  reg [CHAN_WIDTH-1:0] pendingChannel_r;
  reg channelPending_r;
  reg [1:0] calState_r;
  reg calRefLost_r;
  reg missingRef_r;
  reg [3:0] cmpSync1_r;
  reg [3:0] cmpSync2_r;
  reg [1:0] extSync_r;
  reg [15:0] oscCount_r;
  reg oscClock_r;
  reg [7:0] awAddr_r;
  reg awHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg wHeld_r;

  wire refDetectEnable = config_r[`ARD_CFG_REF_DETECT_ENABLE];
  wire refChoice = config_r[`ARD_CFG_REFERENCE_CHOICE];
  wire selBelowLow = refChoice ? cmpSync2_r[2] : cmpSync2_r[0]; // RL8
  wire selAboveHigh = refChoice ? cmpSync2_r[3] : cmpSync2_r[1]; // RL8
  wire writeGo = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire writeCal = writeGo && awAddr_r == `ARD_OFF_CAL_CTRL;
  wire writeStatus = writeGo && awAddr_r == `ARD_OFF_STATUS;
  wire [3:0] statusEvents;
  reg [3:0] statusSet;
  reg [31:0] mergedWrite;
  reg missingRefNxt;
  integer i;

  // Byte-enable merge of the held write data with the addressed register.
  always @* begin
    mergedWrite = 32'h0000_0000;
    case (awAddr_r)
      `ARD_OFF_CONFIG: mergedWrite = config_r;
      `ARD_OFF_IRQ_MASK: mergedWrite = {28'h000_0000, irqMask_r};
      `ARD_OFF_OFFSET_COEF: mergedWrite = {8'h00, offsetCoef_r};
      `ARD_OFF_FULLSCALE_COEF: mergedWrite = {8'h00, fullScaleCoef_r};
      `ARD_OFF_CHANNEL: mergedWrite = {{(32-CHAN_WIDTH){1'b0}}, pendingChannel_r};
      default: mergedWrite = 32'h0000_0000;
    endcase
    for (i = 0; i < 4; i = i + 1) begin
      if (wStrb_r[i]) begin
        mergedWrite[i*8 +: 8] = wData_r[i*8 +: 8];
      end
    end
  end

  // Hysteresis: with detection enabled only a clear crossing moves the flag; between thresholds it holds; detect-enable low clears it.
  always @* begin
    missingRefNxt = missingRef_r; // RL13 RL4
    if (!refDetectEnable) begin
      missingRefNxt = 1'b0; // RL1
    end else if (selBelowLow) begin
      missingRefNxt = 1'b1; // RL2
    end else if (selAboveHigh) begin
      missingRefNxt = 1'b0; // RL3
    end
  end

  assign statusEvents[`ARD_ST_MISSING_REF] = missingRefNxt && !missingRef_r;
  assign statusEvents[`ARD_ST_ERROR] = calState_r != CAL_IDLE && calibrationDone && (calRefLost_r || missingRef_r);
  assign statusEvents[`ARD_ST_RESULT_READY] = conversionDone && calState_r == CAL_IDLE;
  assign statusEvents[`ARD_ST_CAL_DONE] = calState_r != CAL_IDLE && calibrationDone;

  always @* begin
    statusSet = statusEvents;
  end

  // Comparator and external clock synchronisers.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmpSync1_r <= 4'h0;
      cmpSync2_r <= 4'h0;
      extSync_r <= 2'h0;
      missingRef_r <= 1'b0;
    end else begin
      cmpSync1_r <= {secondRefAboveHigh, secondRefBelowLow, firstRefAboveHigh, firstRefBelowLow};
      cmpSync2_r <= cmpSync1_r; // RL13
      extSync_r <= {extSync_r[0], extClockIn};
      missingRef_r <= missingRefNxt;
    end
  end

  // Internal oscillator model by division, and master clock selection.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oscCount_r <= 16'h0000;
      oscClock_r <= 1'b0;
      masterClock <= 1'b0;
      clockOutPin <= 1'b0;
      clockOutPinEnable_n <= 1'b1;
    end else begin
      if (oscCount_r >= OSC_DIV - 16'h0001) begin
        oscCount_r <= 16'h0000;
        oscClock_r <= !oscClock_r;
      end else begin
        oscCount_r <= oscCount_r + 16'h0001;
      end
      masterClock <= config_r[`ARD_CFG_EXT_CLOCK] ? extSync_r[1] : oscClock_r; // RL12
      clockOutPin <= oscClock_r; // RL12
      clockOutPinEnable_n <= !(config_r[`ARD_CFG_CLOCK_OUT_ENABLE] && !config_r[`ARD_CFG_EXT_CLOCK]); // RL12
    end
  end

  // AXI4-Lite slave, register writes, calibration and conversion handling.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awAddr_r <= 8'h00;
      awHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      wHeld_r <= 1'b0;
      config_r <= `ARD_CFG_RESET;
      status_r <= 4'h0;
      irqMask_r <= 4'h0;
      offsetCoef_r <= `ARD_OFFSET_COEF_RESET;
      fullScaleCoef_r <= `ARD_FULLSCALE_COEF_RESET;
      result_r <= {RESULT_WIDTH{1'b0}};
      pendingChannel_r <= {CHAN_WIDTH{1'b0}};
      channelPending_r <= 1'b0;
      activeChannel <= {CHAN_WIDTH{1'b0}};
      conversionRestart <= 1'b0;
      calState_r <= CAL_IDLE;
      calRefLost_r <= 1'b0;
      offsetCalRunning <= 1'b0;
      fullScaleCalRunning <= 1'b0;
      secondRefPinsAsReference <= 1'b0;
      gainSelect <= `ARD_GAIN_1;
      bufferEnable <= 1'b0;
      calibrationValueOut <= `ARD_OFFSET_COEF_RESET;
      irq <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (writeGo) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awAddr_r)
          `ARD_OFF_CONFIG: config_r <= mergedWrite;
          `ARD_OFF_IRQ_MASK: irqMask_r <= mergedWrite[3:0];
          `ARD_OFF_OFFSET_COEF: offsetCoef_r <= mergedWrite[23:0];
          `ARD_OFF_FULLSCALE_COEF: fullScaleCoef_r <= mergedWrite[23:0];
          `ARD_OFF_CHANNEL: begin
            pendingChannel_r <= mergedWrite[CHAN_WIDTH-1:0];
            channelPending_r <= 1'b1;
          end
          `ARD_OFF_STATUS, `ARD_OFF_CAL_CTRL, `ARD_OFF_RESULT: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // Sticky status: a new event wins over a write-one-to-clear.
      status_r <= (status_r & ~(writeStatus ? mergedWrite[3:0] : 4'h0)) | statusSet;
      // The interrupt follows the next status value, so it rises and falls with the status bits.
      irq <= |(((status_r & ~(writeStatus ? mergedWrite[3:0] : 4'h0)) | statusSet) & irqMask_r);
      secondRefPinsAsReference <= refChoice; // RL8
      gainSelect <= config_r[`ARD_CFG_GAIN_MSB:`ARD_CFG_GAIN_LSB]; // RL9
      bufferEnable <= config_r[`ARD_CFG_BUFFER_ENABLE]; // RL10
      conversionRestart <= 1'b0;
      if (conversionDone && calState_r == CAL_IDLE) begin
        result_r <= missingRef_r ? {RESULT_WIDTH{1'b1}} : conversionResult; // RL5
        if (channelPending_r) begin
          activeChannel <= pendingChannel_r; // RL11
          channelPending_r <= 1'b0;
          conversionRestart <= 1'b1; // RL11
        end
      end
      // Calibration sequence with the coefficient update guarded by reference presence.
      case (calState_r)
        CAL_IDLE: begin
          calRefLost_r <= 1'b0;
          if (writeCal && mergedWrite[`ARD_CAL_START_OFFSET]) begin
            calState_r <= CAL_OFFSET;
            offsetCalRunning <= 1'b1;
          end else if (writeCal && mergedWrite[`ARD_CAL_START_FULLSCALE]) begin
            calState_r <= CAL_FULLSCALE;
            fullScaleCalRunning <= 1'b1;
          end
        end
        CAL_OFFSET, CAL_FULLSCALE: begin
          if (missingRef_r) begin
            calRefLost_r <= 1'b1; // RL6
          end
          if (calibrationDone) begin
            if (!(calRefLost_r || missingRef_r)) begin
              if (calState_r == CAL_OFFSET) begin
                offsetCoef_r <= conversionResult[23:0]; // RL6
              end else begin
                fullScaleCoef_r <= conversionResult[23:0]; // RL6
              end
            end
            calState_r <= CAL_IDLE;
            offsetCalRunning <= 1'b0;
            fullScaleCalRunning <= 1'b0;
          end
        end
        default: calState_r <= CAL_IDLE;
      endcase
      calibrationValueOut <= (calState_r == CAL_FULLSCALE) ? fullScaleCoef_r : offsetCoef_r;
    end
  end

  // Read channel: address taken, data answered one cycle later.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `ARD_OFF_CONFIG: s_axi_rdata <= config_r;
          `ARD_OFF_STATUS: s_axi_rdata <= {28'h000_0000, status_r[3:2], status_r[1], missingRef_r}; // RL2
          `ARD_OFF_IRQ_MASK: s_axi_rdata <= {28'h000_0000, irqMask_r};
          `ARD_OFF_CAL_CTRL: s_axi_rdata <= {30'h0000_0000, fullScaleCalRunning, offsetCalRunning};
          `ARD_OFF_OFFSET_COEF: s_axi_rdata <= {8'h00, offsetCoef_r};
          `ARD_OFF_FULLSCALE_COEF: s_axi_rdata <= {8'h00, fullScaleCoef_r};
          `ARD_OFF_RESULT: s_axi_rdata <= {{(32-RESULT_WIDTH){1'b0}}, result_r};
          `ARD_OFF_CHANNEL: s_axi_rdata <= {{(32-CHAN_WIDTH){1'b0}}, activeChannel};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ard_reference_control
